// File: common/scsf_pkg.sv
// Shared constants and types of the system clock select and failover block
package scsf_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] OSC_CONFIG_IDX = 12'hF86;
   localparam logic [11:0] OSC_STATUS_IDX = 12'hF87;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;

   // Unlock values
   localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
   localparam logic [7:0] UNLOCK_SECOND = 8'h18;

   // Configuration field positions
   localparam int CFG_INT_EN_POS = 7;
   localparam int CFG_WDT_EN_POS = 5;
   localparam int CFG_POF_EN_POS = 4;
   localparam int CFG_WDF_EN_POS = 3;
   localparam int CFG_SEL_LSB = 0;
   localparam logic [7:0] CFG_RESET = 8'hA0;

   // Status field positions
   localparam int STS_PRIM_FAIL_POS = 0;
   localparam int STS_WDOG_FAIL_POS = 1;
   localparam int STS_FAILOVER_POS = 2;
   localparam int STS_HALTED_POS = 3;
   localparam int STS_SEL_LSB = 4;

   // Source select codes
   localparam logic [2:0] SEL_IPO_FAST = 3'h0;
   localparam logic [2:0] SEL_IPO_SLOW = 3'h1;
   localparam logic [2:0] SEL_WDOG = 3'h3;
   localparam logic [2:0] SEL_EXT = 3'h4;

   // Timing: primary failure below 1 kHz means no edge for one period
   localparam int CLK_PERIOD_PS = 8000;
   localparam longint PRIM_FAIL_PERIOD_PS = 64'd1000000000;
   localparam int PRIM_FAIL_CYCLES = int'(PRIM_FAIL_PERIOD_PS / CLK_PERIOD_PS);
   localparam int WDOG_FAIL_SYSCLKS = 8004;

   // Configuration register image
   typedef struct packed {
      logic internal_osc_en;
      logic reserved;
      logic wdog_osc_en;
      logic primary_fail_detect_en;
      logic wdog_osc_fail_detect_en;
      logic [2:0] clock_source_select;
   } scsf_cfg_t;

   // Oscillator levels offered to the clock switch
   typedef struct packed {
      logic ext_clk;
      logic wdog_clk;
      logic ipo_slow_clk;
      logic ipo_fast_clk;
   } scsf_src_t;
endpackage

// File: rtl/scsf_edge_watch.sv
// Counts steps without an edge of a watched clock and flags a failure
`timescale 1ns/1ps
`default_nettype none
module scsf_edge_watch #(
   parameter int LIMIT = 8004,
   parameter int CNT_W = 18
) (
   // Clock and control
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Watch inputs
   input wire logic arm_i,
   input wire logic step_i,
   input wire logic edge_i,
   // Result
   output logic fail_o
);
   logic [CNT_W-1:0] cnt_reg;

   initial begin
      if (LIMIT < 1 || LIMIT >= (1 << CNT_W)) begin
         $error("scsf_edge_watch: LIMIT does not fit CNT_W");
      end
   end

   // An edge or disarm restarts the window; fail pulses once at the limit
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
         fail_o <= 1'b0;
      end else if (ce_i) begin
         fail_o <= 1'b0;
         if (!arm_i || edge_i) begin
            cnt_reg <= '0;
         end else if (step_i && cnt_reg != CNT_W'(LIMIT)) begin
            cnt_reg <= cnt_reg + 1'b1;
            fail_o <= (cnt_reg == CNT_W'(LIMIT - 1));
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/scsf_clk_switch.sv
// Break-before-make switch between oscillator levels
`timescale 1ns/1ps
`default_nettype none
module scsf_clk_switch (
   // Clock and control
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Sources and choice
   input wire scsf_pkg::scsf_src_t src_i,
   input wire logic [1:0] want_i,
   input wire logic run_i,
   // Output clock level and the source now driving it
   output logic clk_o,
   output logic [1:0] cur_o
);
   logic parked_reg;

   // Leave the old source only while it is low and join the new one only
   // while it is low too, so no high phase is ever cut short
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cur_o <= 2'h0;
         parked_reg <= 1'b0;
         clk_o <= 1'b0;
      end else if (ce_i) begin
         if (!parked_reg) begin
            if ((want_i != cur_o || !run_i) && !src_i[cur_o]) begin
               parked_reg <= 1'b1;
               clk_o <= 1'b0;
            end else begin
               clk_o <= src_i[cur_o];
            end
         end else if (run_i && !src_i[want_i]) begin
            cur_o <= want_i;
            parked_reg <= 1'b0;
            clk_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/scsf_top.sv
// System clock select, configuration lock and oscillator failure detection
`timescale 1ns/1ps
`default_nettype none
module scsf_top #(
   parameter int PRIM_FAIL_CYCLES = scsf_pkg::PRIM_FAIL_CYCLES,
   parameter int WDOG_FAIL_SYSCLKS = scsf_pkg::WDOG_FAIL_SYSCLKS
) (
   // Clock, reset and clock enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Avalon-MM slave
   input wire logic [scsf_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [scsf_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [scsf_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Oscillator levels, synchronous to mclk_i
   input wire scsf_pkg::scsf_src_t osc_i,
   // Oscillator enables
   output logic internal_osc_en_o,
   output logic wdog_osc_en_o,
   // System clock and events
   output logic sys_clk_o,
   output logic primary_fail_evt_o,
   output logic wdog_fail_evt_o,
   output logic halted_o
);
   initial begin
      if (PRIM_FAIL_CYCLES < 2 || PRIM_FAIL_CYCLES >= (1 << 18)) begin
         $error("scsf_top: PRIM_FAIL_CYCLES out of range");
      end
      if (WDOG_FAIL_SYSCLKS < 2 || WDOG_FAIL_SYSCLKS >= (1 << 18)) begin
         $error("scsf_top: WDOG_FAIL_SYSCLKS out of range");
      end
   end

   // Unlock progress
   typedef enum logic [1:0] {
      SCSF_LOCKED,
      SCSF_GOT_FIRST,
      SCSF_OPEN
   } scsf_lock_t;

   scsf_lock_t lock_reg;
   scsf_pkg::scsf_cfg_t cfg_reg;
   logic prim_flag_reg;
   logic wdog_dead_reg;
   logic failover_reg;
   logic halted_reg;
   logic [2:0] eff_sel;
   logic [1:0] want_idx;
   logic [1:0] cur_idx;
   logic run_src;
   logic sw_clk;
   logic sys_clk_q_reg;
   logic wdog_q_reg;
   logic prim_fail;
   logic wdog_fail;
   logic acc_taken;
   logic wr_now;
   logic cfg_hit;
   logic sts_hit;
   logic [7:0] wbyte;
   logic [7:0] sts_byte;

   // Maps a select code to its oscillator lane
   function automatic logic [1:0] sel_to_lane(input logic [2:0] sel);
      logic [1:0] lane;
      lane = 2'h0;
      unique case (sel)
         scsf_pkg::SEL_IPO_SLOW: lane = 2'h1;
         scsf_pkg::SEL_WDOG: lane = 2'h2;
         scsf_pkg::SEL_EXT: lane = 2'h3;
         default: lane = 2'h0;
      endcase
      return lane;
   endfunction

   // Decodes a byte address into a register index hit
   function automatic logic idx_hit(input logic [scsf_pkg::ADDR_W-1:0] addr,
                                    input logic [11:0] idx);
      return addr[1:0] == 2'h0 && addr[scsf_pkg::ADDR_W-1:2] == idx;
   endfunction

   // Bus decode; a request is answered in the one cycle in which waitrequest is low
   assign cfg_hit = idx_hit(avs_address_i, scsf_pkg::OSC_CONFIG_IDX);
   assign sts_hit = idx_hit(avs_address_i, scsf_pkg::OSC_STATUS_IDX);
   assign acc_taken = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   assign wr_now = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];

   // Waitrequest stays high by default and drops for exactly one cycle
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (ce_i) begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      end
   end

   // Status image read by software
   always_comb begin
      sts_byte = 8'h00;
      sts_byte[scsf_pkg::STS_PRIM_FAIL_POS] = prim_flag_reg;
      sts_byte[scsf_pkg::STS_WDOG_FAIL_POS] = wdog_dead_reg;
      sts_byte[scsf_pkg::STS_FAILOVER_POS] = failover_reg;
      sts_byte[scsf_pkg::STS_HALTED_POS] = halted_reg;
      sts_byte[scsf_pkg::STS_SEL_LSB +: 3] = eff_sel;
   end

   // Read data is loaded as waitrequest drops; unmapped addresses read zero
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         avs_readdata_o <= '0;
      end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
         if (cfg_hit) begin
            avs_readdata_o <= {24'h000000, cfg_reg};
         end else if (sts_hit) begin
            avs_readdata_o <= {24'h000000, sts_byte};
         end else begin
            avs_readdata_o <= '0;
         end
      end
   end

   // Lock sequence; only writes to the configuration index move it, so other
   // accesses in between are harmless, and halted blocks everything
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         lock_reg <= SCSF_LOCKED;
      end else if (ce_i && wr_now && cfg_hit && !halted_reg) begin
         unique case (lock_reg)
            SCSF_LOCKED: begin
               if (wbyte == scsf_pkg::UNLOCK_FIRST) begin
                  lock_reg <= SCSF_GOT_FIRST;
               end
            end
            SCSF_GOT_FIRST: begin
               if (wbyte == scsf_pkg::UNLOCK_SECOND) begin
                  lock_reg <= SCSF_OPEN;
               end else if (wbyte != scsf_pkg::UNLOCK_FIRST) begin
                  lock_reg <= SCSF_LOCKED;
               end
            end
            SCSF_OPEN: begin
               lock_reg <= SCSF_LOCKED;
            end
         endcase
      end
   end

   // Configuration commits only on the write that follows a full unlock.
   // Reserved bit is kept zero; enables and select are independent fields,
   // so detection can be turned on by any later committed write.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cfg_reg <= scsf_pkg::CFG_RESET;
      end else if (ce_i && wr_now && cfg_hit && !halted_reg
                   && lock_reg == SCSF_OPEN) begin
         cfg_reg <= scsf_pkg::scsf_cfg_t'({wbyte[7], 1'b0, wbyte[5:0]});
      end
   end

   // Oscillator enables follow software only; a source change never
   // switches the internal oscillator off by itself
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         internal_osc_en_o <= 1'b1;
         wdog_osc_en_o <= 1'b1;
      end else if (ce_i) begin
         internal_osc_en_o <= cfg_reg.internal_osc_en;
         wdog_osc_en_o <= cfg_reg.wdog_osc_en;
      end
   end

   // Failover holds the watchdog clock until software commits a new setting
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         failover_reg <= 1'b0;
      end else if (ce_i) begin
         if (prim_fail && cfg_reg.wdog_osc_en
             && cfg_reg.clock_source_select != scsf_pkg::SEL_WDOG) begin
            failover_reg <= 1'b1;
         end else if (wr_now && cfg_hit && !halted_reg && lock_reg == SCSF_OPEN) begin
            failover_reg <= 1'b0;
         end
      end
   end

   // Effective source; reserved codes fall back to the fast internal rate
   assign eff_sel = failover_reg ? scsf_pkg::SEL_WDOG : cfg_reg.clock_source_select;
   assign want_idx = sel_to_lane(eff_sel);

   // A source counts as running unless its oscillator is switched off
   always_comb begin
      run_src = 1'b1;
      unique case (want_idx)
         2'h0, 2'h1: run_src = cfg_reg.internal_osc_en;
         2'h2: run_src = cfg_reg.wdog_osc_en;
         default: run_src = 1'b1;
      endcase
   end

   // The switch parks low between sources so no pulse is shortened
   scsf_clk_switch u_switch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .src_i(osc_i),
      .want_i(want_idx),
      .run_i(run_src && !halted_reg),
      .clk_o(sw_clk),
      .cur_o(cur_idx)
   );

   // Edge history of the system clock and the watchdog oscillator
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sys_clk_q_reg <= 1'b0;
         wdog_q_reg <= 1'b0;
         sys_clk_o <= 1'b0;
      end else if (ce_i) begin
         sys_clk_q_reg <= sw_clk;
         wdog_q_reg <= osc_i.wdog_clk;
         sys_clk_o <= sw_clk;
      end
   end

   // Primary detector: no system clock edge for one threshold period.
   // It is blind after a watchdog failure and once failover has happened.
   scsf_edge_watch #(
      .LIMIT(PRIM_FAIL_CYCLES),
      .CNT_W(18)
   ) u_prim_watch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .arm_i(cfg_reg.primary_fail_detect_en && !wdog_dead_reg
             && !failover_reg),
      .step_i(1'b1),
      .edge_i(sw_clk && !sys_clk_q_reg),
      .fail_o(prim_fail)
   );

   // Watchdog detector counts system clock edges, not master clocks
   scsf_edge_watch #(
      .LIMIT(WDOG_FAIL_SYSCLKS),
      .CNT_W(18)
   ) u_wdog_watch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .arm_i(cfg_reg.wdog_osc_fail_detect_en && !wdog_dead_reg),
      .step_i(sw_clk && !sys_clk_q_reg),
      .edge_i(osc_i.wdog_clk && !wdog_q_reg),
      .fail_o(wdog_fail)
   );

   // Event pulses to the processor; neither can be masked here
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         primary_fail_evt_o <= 1'b0;
         wdog_fail_evt_o <= 1'b0;
      end else if (ce_i) begin
         primary_fail_evt_o <= prim_fail;
         wdog_fail_evt_o <= wdog_fail;
      end
   end

   // Primary flag: write one to clear, a new failure wins over the clear
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prim_flag_reg <= 1'b0;
      end else if (ce_i) begin
         if (prim_fail) begin
            prim_flag_reg <= 1'b1;
         end else if (wr_now && sts_hit && wbyte[scsf_pkg::STS_PRIM_FAIL_POS]) begin
            prim_flag_reg <= 1'b0;
         end
      end
   end

   // Watchdog failure is remembered until reset; it never moves the clock
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wdog_dead_reg <= 1'b0;
      end else if (ce_i && wdog_fail) begin
         wdog_dead_reg <= 1'b1;
      end
   end

   // Selected oscillator off with primary detection off: the part stops and
   // only reset brings it back, because the bus can no longer commit writes
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         halted_reg <= 1'b0;
         halted_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_src && !cfg_reg.primary_fail_detect_en) begin
            halted_reg <= 1'b1;
         end
         halted_o <= halted_reg || (!run_src && !cfg_reg.primary_fail_detect_en);
      end
   end

   // Reads and writes to unmapped addresses complete with no effect;
   // acc_taken and cur_idx are unused and only folded into unused_ok for lint
   logic unused_ok;
   assign unused_ok = acc_taken ^ (^cur_idx) ^ (^avs_writedata_i[31:8]);
endmodule
`default_nettype wire

// File: test/scsf_top_asserts.sv
// Port-level checks of the clock select block
`timescale 1ns/1ps
`default_nettype none
module scsf_top_asserts #(
   parameter int PRIM_FAIL_CYCLES = 50,
   parameter int WDOG_FAIL_SYSCLKS = 20
) (
   // Clock, reset and bus
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [scsf_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [scsf_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [scsf_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Oscillators and results
   input wire scsf_pkg::scsf_src_t osc_i,
   input wire logic internal_osc_en_o,
   input wire logic wdog_osc_en_o,
   input wire logic sys_clk_o,
   input wire logic primary_fail_evt_o,
   input wire logic wdog_fail_evt_o,
   input wire logic halted_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   int sys_gap;
   int wd_rises;
   logic sys_q;
   logic wd_q;
   logic wd_failed;
   // Gaps seen at the pins; margins cover the two-cycle output lag
   always_ff @(posedge mclk_i) begin
      sys_q <= sys_clk_o;
      wd_q <= osc_i.wdog_clk;
      sys_gap <= (rst_i || (sys_clk_o && !sys_q)) ? 0 : sys_gap + 1;
      if (rst_i || (osc_i.wdog_clk && !wd_q)) begin
         wd_rises <= 0;
      end else if (sys_clk_o && !sys_q) begin
         wd_rises <= wd_rises + 1;
      end
      wd_failed <= rst_i ? 1'b0 : (wd_failed || wdog_fail_evt_o);
   end
   sequence s_req_rise;
      $rose(avs_read_i || avs_write_i);
   endsequence
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_bus_answer: assert property (s_req_rise |=> s_answer)
      else $error("bus answer not one cycle after request");
   a_idle_quiet: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
      else $error("answer without request");
   a_read_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 0)
      else $error("upper read bits not zero");
   a_osc_en_reset: assert property ($fell(rst_i) |-> internal_osc_en_o && wdog_osc_en_o)
      else $error("oscillator enables not set after reset");
   a_prim_pulse: assert property (primary_fail_evt_o |=> !primary_fail_evt_o)
      else $error("primary event longer than one cycle");
   a_prim_gap: assert property (primary_fail_evt_o |-> sys_gap >= PRIM_FAIL_CYCLES - 2)
      else $error("primary event while clock still running");
   a_wdog_pulse: assert property (wdog_fail_evt_o |=> !wdog_fail_evt_o)
      else $error("watchdog event longer than one cycle");
   a_wdog_count: assert property (wdog_fail_evt_o |-> wd_rises >= WDOG_FAIL_SYSCLKS - 1)
      else $error("watchdog event before its count");
   a_prim_after_wdog: assert property (wd_failed |-> !primary_fail_evt_o)
      else $error("primary event after watchdog failure");
   a_halt_sticky: assert property (halted_o |=> halted_o)
      else $error("halt released without reset");
endmodule
bind scsf_top scsf_top_asserts #(.PRIM_FAIL_CYCLES(PRIM_FAIL_CYCLES),
   .WDOG_FAIL_SYSCLKS(WDOG_FAIL_SYSCLKS)) scsf_top_asserts_inst (.mclk_i(mclk_i),
   .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .osc_i(osc_i),
   .internal_osc_en_o(internal_osc_en_o), .wdog_osc_en_o(wdog_osc_en_o),
   .sys_clk_o(sys_clk_o), .primary_fail_evt_o(primary_fail_evt_o),
   .wdog_fail_evt_o(wdog_fail_evt_o), .halted_o(halted_o));
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the clock select block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [scsf_pkg::ADDR_W-1:0] CFG_A = 14'h3E18;
   localparam logic [scsf_pkg::ADDR_W-1:0] STS_A = 14'h3E1C;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [scsf_pkg::ADDR_W-1:0] avs_address_i = 14'h0000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [scsf_pkg::DATA_W-1:0] avs_writedata_i = 32'h00000000;
   logic [scsf_pkg::DATA_W-1:0] avs_readdata_o;
   logic avs_waitrequest_o, internal_osc_en_o, wdog_osc_en_o, sys_clk_o;
   logic primary_fail_evt_o, wdog_fail_evt_o, halted_o;
   scsf_pkg::scsf_src_t osc_i = '0;
   logic [3:0] run_osc = 4'hF;
   logic [3:0] cyc = 4'h0;
   logic [7:0] rd;
   int err_count = 0;
   int tests_run = 0;
   int n;
   scsf_top #(.PRIM_FAIL_CYCLES(50), .WDOG_FAIL_SYSCLKS(20)) scsf_top_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .osc_i(osc_i),
      .internal_osc_en_o(internal_osc_en_o), .wdog_osc_en_o(wdog_osc_en_o),
      .sys_clk_o(sys_clk_o), .primary_fail_evt_o(primary_fail_evt_o),
      .wdog_fail_evt_o(wdog_fail_evt_o), .halted_o(halted_o));
   // 125 MHz master clock
   always #4 mclk_i = ~mclk_i;
   // Oscillator levels: fast 2, ext 4, watchdog 8, slow 16 cycles; a stopped one sits low
   always @(posedge mclk_i) begin
      cyc <= cyc + 4'h1;
      osc_i <= scsf_pkg::scsf_src_t'(run_osc & {cyc[1], cyc[2], cyc[3], cyc[0]});
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      check(what, {7'h00, exp}, {7'h00, got});
   endtask
   // One bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
      int k;
      k = 0;
      avs_address_i <= a;
      avs_writedata_i <= {24'h000000, d};
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge mclk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o[7:0];
      check("bus wait", 8'h02, k[7:0]);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic cfg(input logic [7:0] d);
      bus(1'b1, CFG_A, 8'hE7);
      bus(1'b1, CFG_A, 8'h18);
      bus(1'b1, CFG_A, d);
   endtask
   task automatic wait_hi(ref logic s);
      n = 0;
      while (s !== 1'b1 && n < 300) begin
         @(posedge mclk_i);
         n++;
      end
   endtask
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // Master cycles from one rise of the system clock to the next
   task automatic sys_period;
      n = 0;
      for (int s = 0; s < 4; s++) begin
         do begin
            @(posedge mclk_i);
            if (s > 1) n++;
         end while (sys_clk_o !== s[0] && n < 100);
      end
   endtask
   // Clock enable low must hold the system clock level still
   task automatic t_freeze;
      logic q;
      ce_i <= 1'b0;
      @(posedge mclk_i);
      q = sys_clk_o;
      n = 0;
      repeat (20) begin
         @(posedge mclk_i);
         if (sys_clk_o !== q) n++;
      end
      check("frozen clock", 8'h00, n[7:0]);
      ce_i <= 1'b1;
      @(posedge mclk_i);
   endtask
   task automatic t_lock;
      bus(1'b0, CFG_A, 8'h00);
      check("config reset", 8'hA0, rd);
      check_bit("ipo on", 1'b1, internal_osc_en_o);
      bus(1'b1, CFG_A, 8'h55);
      bus(1'b1, CFG_A, 8'h18);
      bus(1'b1, CFG_A, 8'hE7);
      bus(1'b1, CFG_A, 8'h55);
      bus(1'b0, CFG_A, 8'h00);
      check("config locked", 8'hA0, rd);
      bus(1'b1, CFG_A, 8'hE7);
      bus(1'b0, STS_A, 8'h00);
      bus(1'b1, 14'h0004, 8'h11);
      bus(1'b1, CFG_A, 8'h18);
      bus(1'b0, 14'h0004, 8'h00);
      check("unmapped", 8'h00, rd);
      bus(1'b1, CFG_A, 8'hA1);
      bus(1'b0, CFG_A, 8'h00);
      check("config unlocked", 8'hA1, rd);
      bus(1'b1, CFG_A, 8'hA0);
      bus(1'b0, CFG_A, 8'h00);
      check("config relocked", 8'hA1, rd);
   endtask
   task automatic t_select;
      logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
      logic [7:0] pers [4] = '{8'h02, 8'h10, 8'h08, 8'h04};
      foreach (codes[i]) begin
         cfg({5'b10100, codes[i]});
         for (int k = 0; k < 20 && ((rd >> 4) & 8'h07) !== {5'h00, codes[i]}; k++) begin
            bus(1'b0, STS_A, 8'h00);
         end
         check("select", {5'h00, codes[i]}, (rd >> 4) & 8'h07);
         repeat (40) @(posedge mclk_i);
         sys_period;
         check("sys period", pers[i], n[7:0]);
      end
      check_bit("ipo kept", 1'b1, internal_osc_en_o);
      cfg(8'h24);
      @(posedge mclk_i);
      check_bit("ipo cleared", 1'b0, internal_osc_en_o);
      check_bit("wdog en kept", 1'b1, wdog_osc_en_o);
      cfg(8'hA0);
   endtask
   task automatic t_failover;
      cfg(8'hB0);
      run_osc <= 4'hE;
      wait_hi(primary_fail_evt_o);
      check_bit("prim event", 1'b1, primary_fail_evt_o);
      check_bit("prim threshold", 1'b1, n >= 25 && n <= 75);
      bus(1'b0, STS_A, 8'h00);
      check("failover", 8'h05, rd & 8'h05);
      run_osc <= 4'hF;
      cfg(8'hA0);
      bus(1'b0, STS_A, 8'h00);
      check("failover off", 8'h00, rd & 8'h04);
      bus(1'b1, STS_A, 8'h01);
      bus(1'b0, STS_A, 8'h00);
      check("flag cleared", 8'h00, rd & 8'h01);
   endtask
   task automatic t_no_failover;
      logic [7:0] cfgs [2] = '{8'h90, 8'hB3};
      logic [3:0] stops [2] = '{4'hE, 4'hB};
      foreach (cfgs[i]) begin
         cfg(cfgs[i] & 8'hE7);
         cfg(cfgs[i]);
         run_osc <= stops[i];
         wait_hi(primary_fail_evt_o);
         check_bit("prim event", 1'b1, primary_fail_evt_o);
         check_bit("wdog enable", cfgs[i][5], wdog_osc_en_o);
         bus(1'b0, STS_A, 8'h00);
         check("no failover", 8'h00, rd & 8'h04);
         run_osc <= 4'hF;
         cfg(8'hA0);
      end
   endtask
   task automatic t_wdog_fail;
      cfg(8'hA8);
      run_osc <= 4'hB;
      wait_hi(wdog_fail_evt_o);
      check_bit("wdog event", 1'b1, wdog_fail_evt_o);
      check_bit("wdog count", 1'b1, n >= 38);
      bus(1'b0, STS_A, 8'h00);
      check("wdog status", 8'h02, rd & 8'h76);
      cfg(8'hB8);
      run_osc <= 4'hA;
      n = 0;
      repeat (150) begin
         @(posedge mclk_i);
         if (primary_fail_evt_o === 1'b1) n++;
      end
      check("prim blocked", 8'h00, n[7:0]);
      run_osc <= 4'hF;
      do_reset;
   endtask
   task automatic t_halt;
      cfg(8'h20);
      wait_hi(halted_o);
      check_bit("halted", 1'b1, halted_o);
      cfg(8'hA0);
      bus(1'b0, CFG_A, 8'h00);
      check("halt holds", 8'h20, rd);
      do_reset;
      check_bit("halt cleared", 1'b0, halted_o);
   endtask
   task automatic end_sim;
      $display("Checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence after a two-cycle reset
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_freeze;
      t_lock;
      t_select;
      t_failover;
      t_no_failover;
      t_wdog_fail;
      t_halt;
      end_sim;
   end
   // Hang guard of 20000 cycles, far beyond the fewer than one thousand cycles the tests need
   initial begin
      #160000;
      err_count++;
      $display("Error watchdog expected end seen hang");
      end_sim;
   end
endmodule
`default_nettype wire
